// ===== rtl/ccr_defines.svh
// Constants for the command and configuration register bank.
// Assumes a byte-addressed register port with 8-bit addresses.
//
// Contract
// [R01] Bits 31 to 16 of command_config are reloaded from the configuration EEPROM word; the code reloads bits 31, 23 and 22 to 21 only.
// [R02] With cold_wake_support clear, bit 31 of power_mgmt_reg_first is forced to zero.
// [R03] With cold_wake_support set and auxiliary power seen, that power bit is set to one.
// [R04] The aux_current_load field at bits 30 to 28 reports the auxiliary current need.
// [R05] With the power bit at one, aux_current_load defaults to 111b, meaning 375 mA.
// [R06] With the power bit at zero, aux_current_load defaults to 000b, wake unsupported.
// [R07] With four_indicator_select clear, three indicators show speed, link/act, dup/col.
// [R08] With four_indicator_select set, four show 100 link, 10 link, activity, dup/col.
// [R09] rx_fifo_size code 11 selects 1K bytes, 10 selects 2K bytes, 01 and 00 are reserved.
// [R10] Reserved bits 27 to 24 read as zero and ignore writes.
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

`define CCR_ADDR_CMD_CFG 8'h88
`define CCR_ADDR_PM_STAT 8'h8c

`define CCR_BIT_COLD_WAKE 31
`define CCR_AUX_HI 30
`define CCR_AUX_LO 28
`define CCR_RSV_HI 27
`define CCR_RSV_LO 24
`define CCR_BIT_FOUR_LED 23
`define CCR_RFS_HI 22
`define CCR_RFS_LO 21
`define CCR_LOW_HI 15
`define CCR_LOW_LO 0
`define CCR_BIT_PM_WAKE 31

`define CCR_EE_COLD_WAKE 15
`define CCR_EE_FOUR_LED 7
`define CCR_EE_RFS_HI 6
`define CCR_EE_RFS_LO 5

`define CCR_AUX_FULL 3'h7
`define CCR_AUX_NONE 3'h0
`define CCR_RFS_1K 2'h3
`define CCR_RFS_2K 2'h2
`define CCR_RFS_RESET 2'h2
`define CCR_BYTES_1K 12'h400
`define CCR_BYTES_2K 12'h800
`define CCR_LOW_RESET 16'h0000

`endif

// ===== rtl/ccr_pkg.sv
// Types shared by the command and configuration register bank.
// Assumes ccr_defines.svh is on the include path.
`default_nettype none

package ccr_pkg;

	typedef struct packed {
		logic cold_wake_support;
		logic [2:0] aux_current_load;
		logic four_indicator_select;
		logic [1:0] rx_fifo_size;
		logic [15:0] low_bits;
	} ccr_cfg_type;

	typedef struct packed {
		logic speed100;
		logic link;
		logic activity;
		logic full_duplex;
		logic collision;
	} ccr_phy_stat_type;

endpackage : ccr_pkg

`default_nettype wire

// ===== rtl/ccr_sync.sv
// Two-flop level synchroniser.
// Assumes the input is asynchronous to clk_in.
`default_nettype none

module ccr_sync (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Level
	input wire logic async_in,
	output logic sync_out
);

	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;

endmodule : ccr_sync

`default_nettype wire

// ===== rtl/ccr_command_config.sv
// Command and configuration register with EEPROM reload, wake power bit,
// indicator mapping and receive FIFO size selection.
// Assumes a same-clock register port and EEPROM loader; the auxiliary
// power detect is an asynchronous pin.
`include "ccr_defines.svh"
`default_nettype none

module ccr_command_config
	import ccr_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// EEPROM recall of bits 31, 23 and 22 to 21
	input wire logic ee_load_in,
	input wire logic [15:0] ee_data_in,
	// Power management
	input wire logic aux_power_pin_in,
	output logic pm_cold_wake_out,
	// Indicators
	input wire ccr_phy_stat_type phy_stat_in,
	output logic [3:0] led_out,
	// Configuration outputs
	output logic four_indicator_select_out,
	output logic [11:0] rx_fifo_bytes_out
);

	ccr_cfg_type cfg_r;
	ccr_cfg_type cfg_nxt;
	logic aux_written_r;
	logic aux_written_nxt;
	logic pm_r;
	logic pm_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [3:0] led_r;
	logic [3:0] led_nxt;
	logic [11:0] fifo_bytes_r;
	logic [11:0] fifo_bytes_nxt;
	logic aux_seen;
	logic wr_cmd;
	logic rd_cmd;

	ccr_sync u_aux_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in(aux_power_pin_in),
		.sync_out(aux_seen)
	);

	assign wr_cmd = wr_in && (addr_in == `CCR_ADDR_CMD_CFG);
	assign rd_cmd = rd_in && (addr_in == `CCR_ADDR_CMD_CFG);

	function automatic logic [31:0] cmd_word(input ccr_cfg_type c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`CCR_BIT_COLD_WAKE] = c.cold_wake_support;
		w[`CCR_AUX_HI:`CCR_AUX_LO] = c.aux_current_load;
		w[`CCR_BIT_FOUR_LED] = c.four_indicator_select;
		w[`CCR_RFS_HI:`CCR_RFS_LO] = c.rx_fifo_size;
		w[`CCR_LOW_HI:`CCR_LOW_LO] = c.low_bits;
		return w;
	endfunction : cmd_word

	// Configuration fields: EEPROM recall wins over a software write
	always_comb begin
		cfg_nxt = cfg_r;
		aux_written_nxt = aux_written_r;
		if (ee_load_in) begin
			cfg_nxt.cold_wake_support = ee_data_in[`CCR_EE_COLD_WAKE]; // see [R01]
			cfg_nxt.four_indicator_select = ee_data_in[`CCR_EE_FOUR_LED]; // see [R01]
			if (ee_data_in[`CCR_EE_RFS_HI]) begin
				cfg_nxt.rx_fifo_size = ee_data_in[`CCR_EE_RFS_HI:`CCR_EE_RFS_LO]; // see [R01]
			end
			aux_written_nxt = 1'b0;
		end else if (wr_in && (addr_in == `CCR_ADDR_CMD_CFG)) begin
			cfg_nxt.cold_wake_support = wdata_in[`CCR_BIT_COLD_WAKE];
			cfg_nxt.aux_current_load = wdata_in[`CCR_AUX_HI:`CCR_AUX_LO]; // see [R04]
			aux_written_nxt = 1'b1;
			cfg_nxt.four_indicator_select = wdata_in[`CCR_BIT_FOUR_LED];
			// Reserved size codes are ignored so the FIFO never sees them
			if (wdata_in[`CCR_RFS_HI]) begin
				cfg_nxt.rx_fifo_size = wdata_in[`CCR_RFS_HI:`CCR_RFS_LO]; // see [R09]
			end
			cfg_nxt.low_bits = wdata_in[`CCR_LOW_HI:`CCR_LOW_LO];
		end
		// Until software writes it, the load field follows the wake power bit
		if (!aux_written_nxt) begin
			cfg_nxt.aux_current_load = pm_r ? `CCR_AUX_FULL : `CCR_AUX_NONE; // see [R05] [R06]
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cfg_r.cold_wake_support <= 1'b0;
			cfg_r.aux_current_load <= `CCR_AUX_NONE;
			cfg_r.four_indicator_select <= 1'b0;
			cfg_r.rx_fifo_size <= `CCR_RFS_RESET;
			cfg_r.low_bits <= `CCR_LOW_RESET;
			aux_written_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			aux_written_r <= aux_written_nxt;
		end
	end

	// Wake power bit
	always_comb begin
		pm_nxt = cfg_r.cold_wake_support && aux_seen; // see [R02] [R03]
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pm_r <= 1'b0;
		end else begin
			pm_r <= pm_nxt;
		end
	end

	// Indicators and FIFO size
	always_comb begin
		if (cfg_r.four_indicator_select) begin
			led_nxt[0] = phy_stat_in.link && phy_stat_in.speed100; // see [R08]
			led_nxt[1] = phy_stat_in.link && !phy_stat_in.speed100; // see [R08]
			led_nxt[2] = phy_stat_in.activity; // see [R08]
			led_nxt[3] = phy_stat_in.full_duplex || phy_stat_in.collision; // see [R08]
		end else begin
			led_nxt[0] = phy_stat_in.speed100; // see [R07]
			led_nxt[1] = phy_stat_in.link || phy_stat_in.activity; // see [R07]
			led_nxt[2] = phy_stat_in.full_duplex || phy_stat_in.collision; // see [R07]
			led_nxt[3] = 1'b0;
		end
		case (cfg_r.rx_fifo_size)
			`CCR_RFS_1K: begin
				fifo_bytes_nxt = `CCR_BYTES_1K; // see [R09]
			end
			default: begin
				fifo_bytes_nxt = `CCR_BYTES_2K; // see [R09]
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			led_r <= 4'h0;
			fifo_bytes_r <= `CCR_BYTES_2K;
		end else begin
			led_r <= led_nxt;
			fifo_bytes_r <= fifo_bytes_nxt;
		end
	end

	// Read data, one cycle after the strobe; unmapped reads give zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (rd_in) begin
			case (addr_in)
				`CCR_ADDR_CMD_CFG: begin
					rdata_nxt = cmd_word(cfg_r); // see [R04] [R10]
				end
				`CCR_ADDR_PM_STAT: begin
					rdata_nxt[`CCR_BIT_PM_WAKE] = pm_r;
				end
				default: begin
					rdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_out = rdata_r;
	assign pm_cold_wake_out = pm_r;
	assign led_out = led_r;
	assign four_indicator_select_out = cfg_r.four_indicator_select;
	assign rx_fifo_bytes_out = fifo_bytes_r;

	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_cmd_write;
		wr_cmd && !ee_load_in;
	endsequence

	sequence s_ee_recall;
		ee_load_in;
	endsequence

	chk_ee_reload_bits: assert property ( // see [R01]
		s_ee_recall |=> (cfg_r.cold_wake_support == $past(ee_data_in[`CCR_EE_COLD_WAKE]))
			&& (four_indicator_select_out == $past(ee_data_in[`CCR_EE_FOUR_LED])))
		else $error("EEPROM recall did not load the upper fields");

	chk_pm_forced_low: assert property ( // see [R02]
		!cfg_r.cold_wake_support |=> !pm_cold_wake_out)
		else $error("Wake power bit set while wake support is clear");

	chk_pm_set_aux: assert property ( // see [R03]
		(cfg_r.cold_wake_support && aux_seen) |=> pm_cold_wake_out)
		else $error("Wake power bit not set with support and auxiliary power");

	chk_aux_write_readback: assert property ( // see [R04]
		s_cmd_write ##1 rd_cmd |=> rdata_out[`CCR_AUX_HI:`CCR_AUX_LO]
			== $past(wdata_in[`CCR_AUX_HI:`CCR_AUX_LO], 2))
		else $error("Load field does not read back the written value");

	chk_aux_default_full: assert property ( // see [R05]
		(!aux_written_r && pm_r && !wr_cmd) |=> cfg_r.aux_current_load == `CCR_AUX_FULL)
		else $error("Load field not 111b with wake power bit set");

	chk_aux_default_none: assert property ( // see [R06]
		(!aux_written_r && !pm_r && !wr_cmd) |=> cfg_r.aux_current_load == `CCR_AUX_NONE)
		else $error("Load field not 000b with wake power bit clear");

	chk_led_three_mode: assert property ( // see [R07]
		!cfg_r.four_indicator_select |=> !led_out[3] && (led_out[0] == $past(phy_stat_in.speed100)))
		else $error("Three indicator mapping wrong");

	chk_led_four_mode: assert property ( // see [R08]
		cfg_r.four_indicator_select |=> (led_out[2] == $past(phy_stat_in.activity))
			&& (led_out[1] == $past(phy_stat_in.link && !phy_stat_in.speed100)))
		else $error("Four indicator mapping wrong");

	chk_fifo_size_map: assert property ( // see [R09]
		(cfg_r.rx_fifo_size == `CCR_RFS_1K) |=> rx_fifo_bytes_out == `CCR_BYTES_1K)
		else $error("Size code 11 did not give 1K bytes");

	chk_rsv_read_zero: assert property ( // see [R10]
		rd_cmd |=> rdata_out[`CCR_RSV_HI:`CCR_RSV_LO] == 4'h0)
		else $error("Reserved bits read nonzero");

endmodule : ccr_command_config

`default_nettype wire

// ===== test/ccr_eeprom_model.sv
// Configuration EEPROM loader model that recalls one 16-bit word on request.
// Assumes the bench raises recall_in for one cycle with the word beside it.
`default_nettype none

module ccr_eeprom_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Bench request
	input wire logic recall_in,
	input wire logic [15:0] word_in,
	// Recall port of the register bank
	output logic ee_load_out,
	output logic [15:0] ee_data_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Data toggles every idle cycle so a stale word is never mistaken for a fresh one
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ee_load_out <= 1'b0;
			ee_data_out <= 16'h0000;
		end else if (recall_in) begin
			ee_load_out <= 1'b1;
			ee_data_out <= word_in;
		end else begin
			ee_load_out <= 1'b0;
			ee_data_out <= ~ee_data_out;
		end
	end
endmodule : ccr_eeprom_model

`default_nettype wire

// ===== test/ccr_command_config_tb.sv
// Self-checking bench for the command and configuration register bank.
// Assumes the EEPROM model drives the recall port; the bench drives the rest.
`default_nettype none

module ccr_command_config_tb
	import ccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic aux_pin = 1'b0;
	ccr_phy_stat_type phy = '0;
	logic recall = 1'b0;
	logic [15:0] word = 16'h0000;
	wire logic [31:0] rdata;
	wire logic ee_load;
	wire logic [15:0] ee_data;
	wire logic pm;
	wire logic [3:0] led;
	wire logic four;
	wire logic [11:0] bytes;
	logic cold_e, four_e, aux_sw;
	logic [2:0] aux_e;
	logic [1:0] rfs_e;
	logic [15:0] low_e;
	int n_errors = 0;
	int compares = 0;

	always #5 clk_in = ~clk_in;

	ccr_eeprom_model eeprom (.clk_in(clk_in), .rst_in(rst_in), .recall_in(recall),
		.word_in(word), .ee_load_out(ee_load), .ee_data_out(ee_data));

	ccr_command_config DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
		.ee_load_in(ee_load), .ee_data_in(ee_data), .aux_power_pin_in(aux_pin),
		.pm_cold_wake_out(pm), .phy_stat_in(phy), .led_out(led),
		.four_indicator_select_out(four), .rx_fifo_bytes_out(bytes));

	function automatic logic [31:0] exp_word();
		logic [2:0] a;
		a = aux_sw ? aux_e : ((cold_e & aux_pin) ? 3'h7 : 3'h0);
		return {cold_e, a, 4'h0, four_e, rfs_e, 5'h00, low_e};
	endfunction : exp_word

	function automatic logic [3:0] exp_led(input logic m, input ccr_phy_stat_type p);
		if (m)
			return {p.full_duplex | p.collision, p.activity, p.link & ~p.speed100,
				p.link & p.speed100};
		return {1'b0, p.full_duplex | p.collision, p.link | p.activity, p.speed100};
	endfunction : exp_led

	task automatic end_sim();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata;
	endtask : rd

	// Write then read with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 q = rdata;
	endtask : wr_rd

	// Pin changes pass a synchroniser, so let them settle first; mode[1] forces mode[0]
	task automatic set_pin(input logic [1:0] mode);
		@(posedge clk_in);
		aux_pin <= mode[1] ? mode[0] : 1'($urandom);
		repeat (5) @(posedge clk_in);
	endtask : set_pin

	task automatic recall_word(input logic [15:0] w);
		@(posedge clk_in);
		recall <= 1'b1;
		word <= w;
		@(posedge clk_in);
		recall <= 1'b0;
		repeat (6) @(posedge clk_in);
		cold_e = w[15];
		four_e = w[7];
		aux_sw = 1'b0;
		if (w[6])
			rfs_e = w[6:5];
	endtask : recall_word

	initial begin
		#200000;
		n_errors++;
		$display("watchdog expired");
		end_sim();
	end

	initial begin
		logic [31:0] v, w;
		logic [15:0] e;
		logic [7:0] a;
		v = $urandom(32'h892f);
		{cold_e, four_e, aux_sw, aux_e, rfs_e, low_e} = {3'b000, 3'h0, 2'h2, 16'h0000};
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(8'h88, v);
		chk("reset word", v, 32'h0040_0000);
		chk("reset bytes", bytes, 12'h800);
		for (int i = 0; i < 12; i++) begin
			w = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff_ffff : (i == 2) ? 32'h2020_0000 : $urandom;
			set_pin(2'b00);
			wr_rd(8'h88, w, v);
			{cold_e, aux_e, four_e, low_e, aux_sw} = {w[31:28], w[23], w[15:0], 1'b1};
			if (w[22])
				rfs_e = w[22:21];
			chk("written word", v, exp_word());
			chk("four select", four, four_e);
			chk("fifo bytes", bytes, (rfs_e == 2'h3) ? 12'h400 : 12'h800);
		end
		for (int i = 0; i < 8; i++) begin
			e = (i == 0) ? 16'h8000 : (i == 1) ? 16'h0020 : (i == 2) ? 16'h0060 : 16'($urandom);
			set_pin(2'b00);
			recall_word(e);
			rd(8'h88, v);
			chk("recalled word", v, exp_word());
			chk("power bit", pm, cold_e & aux_pin);
			chk("aux default", v[30:28], (cold_e & aux_pin) ? 3'h7 : 3'h0);
		end
		for (int m = 0; m < 2; m++) begin
			recall_word(m ? 16'h8080 : 16'h0040);
			for (int j = 0; j < 10; j++) begin
				@(posedge clk_in);
				phy <= ccr_phy_stat_type'(5'($urandom));
				@(posedge clk_in);
				@(posedge clk_in);
				#1 chk("indicators", led, exp_led(1'(m), phy));
			end
		end
		// Wake support is set, so auxiliary power drives the status bit and load default high
		set_pin(2'b11);
		wr(8'h8c, 32'h0);
		rd(8'h8c, v);
		chk("status power bit", v[31], cold_e & aux_pin);
		for (int i = 0; i < 4; i++) begin
			a = {1'b0, 7'($urandom)};
			wr(a, $urandom);
			rd(a, v);
			chk("unmapped read", v, 32'h0);
			rd(8'h88, v);
			chk("word kept", v, exp_word());
		end
		end_sim();
	end
endmodule : ccr_command_config_tb

`default_nettype wire
